// File: uieb_top.sv
// What this block does
// - enable register upper four bits always read zero
// - enable bit 3 gates handshake status change onto interrupt
// - enable bit 2 gates receive line error onto interrupt
// - enable bit 1 gates transmit holding empty onto interrupt
// - enable bit 0 gates receive data ready or trigger onto interrupt
// - all enables clear means no port_irq; each source gated alone
// - low and high bytes form 16-bit divisor of pre-divided reference
// - divided output is sixteen times bit rate, shared by tx and rx
// - high-speed mode bits divide undivided 24 MHz by same divisor
// - high-speed divisor one gives 1.5 Mbit/s
// - config selects pre-divider 13, 1.625 or 1.0
// - scratch byte stores and returns any byte, no side effect
// - port_irq output only while handshake control bit 3 is one; the event irq output is not gated by it
// - priority: line, receive, transmit, handshake; code in bits 2:1
//
// Purpose: interrupt enables and rate generator of a serial port
// Assumes: axi4-lite slave, one clock aclk at 200 MHz
// Notes: the 24 MHz reference is a tick derived from aclk
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module uieb_top #(
   parameter int DIV_W = 16
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic line_error_pend, // receive line error pending
   input wire logic rx_ready_pend, // receive data ready or trigger
   input wire logic tx_empty_pend, // transmit holding buffer empty
   input wire logic modem_change_pend, // handshake status change pending
   input wire logic handshake_irq_gate, // handshake control bit 3
   output logic port_irq, // serial port interrupt output
   output logic [1:0] irq_identity, // priority code of pending source
   output logic irq_none, // high when nothing enabled is pending
   output logic baud16_tick, // 16x bit-rate enable pulse
   output logic irq // event interrupt, level
);
   // ---- register state
   logic [3:0] irq_en;
   logic [7:0] div_lo;
   logic [7:0] div_hi;
   logic [7:0] scratch_byte;
   logic [1:0] speed_mode_config;
   logic [1:0] prediv_config;
   logic [1:0] evt_stat;
   logic [1:0] evt_mask;
   logic [DIV_W-1:0] div_cnt;

   // ---- bus state
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // write channel: accept address and data in any order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_held || aw_fire;
   wire have_w = w_held || w_fire;
   wire do_write = have_aw && have_w && !s_axi_bvalid;
   wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
   wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
   wire [7:0] wr_byte = wr_data[7:0];
   wire wr_lane0 = wr_strb[0];

   // write decode
   wire wr_ok = (wr_addr == uieb_pkg::OFS_IRQ_EN)
      || (wr_addr == uieb_pkg::OFS_DIV_LO)
      || (wr_addr == uieb_pkg::OFS_DIV_HI)
      || (wr_addr == uieb_pkg::OFS_SCRATCH)
      || (wr_addr == uieb_pkg::OFS_CONFIG)
      || (wr_addr == uieb_pkg::OFS_IDENT)
      || (wr_addr == uieb_pkg::OFS_EVT_STAT)
      || (wr_addr == uieb_pkg::OFS_EVT_MASK);
   wire wr_en_irq = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_IRQ_EN);
   wire wr_en_lo = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_DIV_LO);
   wire wr_en_hi = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_DIV_HI);
   wire wr_en_scr = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_SCRATCH);
   wire wr_en_cfg = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_CONFIG);
   wire wr_en_mask = do_write && wr_lane0
      && (wr_addr == uieb_pkg::OFS_EVT_MASK);

   // write channel holding registers and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= uieb_pkg::RESP_OKAY;
      end else begin
         if (aw_fire && !do_write) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (w_fire && !do_write) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? uieb_pkg::RESP_OKAY
                                 : uieb_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control registers written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en <= 4'h0;
         div_lo <= uieb_pkg::DIV_RESET[7:0];
         div_hi <= uieb_pkg::DIV_RESET[15:8];
         scratch_byte <= 8'h00;
         speed_mode_config <= 2'h0;
         prediv_config <= uieb_pkg::PREDIV_13;
         evt_mask <= 2'h0;
      end else begin
         if (wr_en_irq) begin
            irq_en <= wr_byte[3:0];
         end
         if (wr_en_lo) begin
            div_lo <= wr_byte;
         end
         if (wr_en_hi) begin
            div_hi <= wr_byte;
         end
         if (wr_en_scr) begin
            scratch_byte <= wr_byte;
         end
         if (wr_en_cfg) begin
            prediv_config <= wr_byte[uieb_pkg::CFG_PREDIV_LSB +: 2];
            speed_mode_config <= wr_byte[uieb_pkg::CFG_SPEED_LSB +: 2];
         end
         if (wr_en_mask) begin
            evt_mask <= wr_byte[1:0];
         end
      end
   end

   // ---- interrupt gating and priority; pending inputs are never stored,
   // so a cleared enable only masks the condition
   wire [3:0] pend = {modem_change_pend, line_error_pend,
                      tx_empty_pend, rx_ready_pend};
   wire [3:0] gated = pend & irq_en;
   wire any_gated = |gated;

   // priority code: line, receive, transmit, handshake
   wire [1:0] next_identity =
      gated[uieb_pkg::EN_LINE] ? uieb_pkg::ID_LINE :
      gated[uieb_pkg::EN_RX] ? uieb_pkg::ID_RX :
      gated[uieb_pkg::EN_TX] ? uieb_pkg::ID_TX :
      uieb_pkg::ID_MODEM;

   // registered interrupt outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_irq <= 1'b0;
         irq_identity <= uieb_pkg::ID_MODEM;
         irq_none <= 1'b1;
      end else begin
         port_irq <= any_gated && handshake_irq_gate;
         irq_identity <= next_identity;
         irq_none <= !any_gated;
      end
   end

   // ---- rate generator: 24 MHz tick, then pre-divide, then divisor
   logic ref24_tick;
   logic pre_tick;
   logic [4:0] pre_step;
   logic [4:0] pre_mod;
   wire high_speed = (speed_mode_config == uieb_pkg::SPEED_HIGH);

   uieb_frac_tick #(.W(5)) u_ref (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(1'b1),
      .step(uieb_pkg::REF_STEP),
      .modulus(uieb_pkg::REF_MOD),
      .tick_out(ref24_tick)
   );

   // pre-divider selection; high speed bypasses it
   assign pre_step = (high_speed || prediv_config == uieb_pkg::PREDIV_1P0)
      ? uieb_pkg::PRE_ONE
      : (prediv_config == uieb_pkg::PREDIV_1P625)
         ? uieb_pkg::PRE_DEN_1P625 : uieb_pkg::PRE_ONE;
   assign pre_mod = (high_speed || prediv_config == uieb_pkg::PREDIV_1P0)
      ? uieb_pkg::PRE_ONE
      : (prediv_config == uieb_pkg::PREDIV_1P625)
         ? uieb_pkg::PRE_NUM_1P625 : uieb_pkg::PRE_NUM_13;

   uieb_frac_tick #(.W(5)) u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(ref24_tick),
      .step(pre_step),
      .modulus(pre_mod),
      .tick_out(pre_tick)
   );

   // programmable divisor: zero is treated as one
   wire [DIV_W-1:0] divisor = DIV_W'({div_hi, div_lo});
   wire [DIV_W-1:0] div_last = (divisor == '0) ? '0
      : DIV_W'(divisor - DIV_W'(1));
   wire div_wrap = pre_tick && (div_cnt >= div_last);

   // 16x tick counter, divisor one passes every pre-divided tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= '0;
         baud16_tick <= 1'b0;
      end else begin
         baud16_tick <= div_wrap;
         if (pre_tick) begin
            div_cnt <= div_wrap ? '0 : DIV_W'(div_cnt + DIV_W'(1));
         end
      end
   end

   // ---- event status: enabled interrupt rises, divisor wrap seen
   logic port_irq_d;
   wire [1:0] evt_set = {baud16_tick, port_irq && !port_irq_d};
   wire rd_stat = s_axi_arvalid && s_axi_arready
      && (s_axi_araddr == uieb_pkg::OFS_EVT_STAT);

   // sticky events, read clears, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_stat <= 2'h0;
         port_irq_d <= 1'b0;
      end else begin
         port_irq_d <= port_irq;
         evt_stat <= (rd_stat ? 2'h0 : evt_stat) | evt_set;
      end
   end

   assign irq = |(evt_stat & evt_mask);

   // ---- read channel
   assign s_axi_arready = !s_axi_rvalid;

   logic [7:0] rd_byte;
   logic rd_ok;
   // read data select
   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         uieb_pkg::OFS_IRQ_EN: rd_byte = {4'h0, irq_en};
         uieb_pkg::OFS_DIV_LO: rd_byte = div_lo;
         uieb_pkg::OFS_DIV_HI: rd_byte = div_hi;
         uieb_pkg::OFS_SCRATCH: rd_byte = scratch_byte;
         uieb_pkg::OFS_CONFIG: rd_byte = {speed_mode_config, 4'h0,
                                          prediv_config};
         uieb_pkg::OFS_IDENT: rd_byte = {5'h00, irq_identity, irq_none};
         uieb_pkg::OFS_EVT_STAT: rd_byte = {6'h00, evt_stat};
         uieb_pkg::OFS_EVT_MASK: rd_byte = {6'h00, evt_mask};
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
   end

   // read response register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= uieb_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_ok ? uieb_pkg::RESP_OKAY : uieb_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : uieb_top

// File: uieb_pkg.sv
// Purpose: shared constants for the serial port enable and rate block
// Assumes: 32-bit axi4-lite register bus, 200 MHz aclk
// Notes: register offsets are byte addresses
package uieb_pkg;
   localparam logic [7:0] OFS_IRQ_EN = 8'h00;
   localparam logic [7:0] OFS_DIV_LO = 8'h04;
   localparam logic [7:0] OFS_DIV_HI = 8'h08;
   localparam logic [7:0] OFS_SCRATCH = 8'h0C;
   localparam logic [7:0] OFS_CONFIG = 8'h10;
   localparam logic [7:0] OFS_IDENT = 8'h14;
   localparam logic [7:0] OFS_EVT_STAT = 8'h18;
   localparam logic [7:0] OFS_EVT_MASK = 8'h1C;
   // interrupt enable field positions
   localparam int EN_RX = 0;
   localparam int EN_TX = 1;
   localparam int EN_LINE = 2;
   localparam int EN_MODEM = 3;
   localparam logic [7:0] IRQ_EN_WMASK = 8'h0F;
   // config register fields
   localparam int CFG_PREDIV_LSB = 0;
   localparam int CFG_SPEED_LSB = 6;
   localparam int CFG_HS_IRQ = 2;
   localparam logic [1:0] SPEED_HIGH = 2'h3;
   localparam logic [1:0] PREDIV_13 = 2'h0;
   localparam logic [1:0] PREDIV_1P625 = 2'h1;
   localparam logic [1:0] PREDIV_1P0 = 2'h2;
   // reference pre-divide as numerator/denominator steps (13, 13/8, 1)
   localparam logic [4:0] PRE_NUM_13 = 5'h0D;
   localparam logic [4:0] PRE_NUM_1P625 = 5'h0D;
   localparam logic [4:0] PRE_DEN_1P625 = 5'h08;
   localparam logic [4:0] PRE_ONE = 5'h01;
   // identity codes reported for priority
   localparam logic [1:0] ID_LINE = 2'h3;
   localparam logic [1:0] ID_RX = 2'h2;
   localparam logic [1:0] ID_TX = 2'h1;
   localparam logic [1:0] ID_MODEM = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // reference 24 MHz tick derived from 200 MHz: phase step 3 of 25
   localparam logic [4:0] REF_STEP = 5'h03;
   localparam logic [4:0] REF_MOD = 5'h19;
   localparam logic [15:0] DIV_RESET = 16'h0001;
endpackage : uieb_pkg

// File: uieb_frac_tick.sv
// Purpose: fractional tick divider, emits step/modulus rate of its input ticks
// Assumes: step not above modulus
// Notes: one-cycle output pulse per wrap
`timescale 1ns/1ps
module uieb_frac_tick #(
   parameter int W = 5
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic tick_in, // input tick
   input wire logic [W-1:0] step, // phase step per tick
   input wire logic [W-1:0] modulus, // wrap value
   output logic tick_out // one-cycle output tick
);
   logic [W-1:0] phase;
   logic [W:0] sum;
   logic wrap;

   // phase accumulate and wrap detect
   assign sum = {1'b0, phase} + {1'b0, step};
   assign wrap = tick_in && (sum >= {1'b0, modulus});

   // accumulator and output pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= wrap;
         if (tick_in) begin
            phase <= wrap ? W'(sum - {1'b0, modulus}) : sum[W-1:0];
         end
      end
   end
endmodule : uieb_frac_tick

// File: uieb_asserts.sv
// Purpose: property checks for the enable and rate block
// Assumes: bound to uieb_top, one clock aclk
// Notes: keeps a shadow of the enable byte from the write channel
`timescale 1ns/1ps
module uieb_asserts (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic [7:0] s_axi_awaddr, // write addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // strobes
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic line_error_pend, // line error
   input wire logic rx_ready_pend, // rx ready
   input wire logic tx_empty_pend, // tx empty
   input wire logic modem_change_pend, // modem change
   input wire logic handshake_irq_gate, // output gate
   input wire logic port_irq, // port interrupt
   input wire logic [1:0] irq_identity, // priority code
   input wire logic irq_none, // nothing pending
   input wire logic baud16_tick // 16x tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic aw_held, w_held, w_s;
   logic [7:0] aw_a, w_d;
   logic [3:0] en_sh, act_q;
   // a write lands when both halves are in, taken now or earlier
   wire aw_now = s_axi_awvalid & s_axi_awready;
   wire w_now = s_axi_wvalid & s_axi_wready;
   wire wr_fire = (aw_now | aw_held) & (w_now | w_held);
   wire [7:0] wr_a = aw_now ? s_axi_awaddr : aw_a;
   wire [7:0] wr_d = w_now ? s_axi_wdata[7:0] : w_d;
   wire wr_s = w_now ? s_axi_wstrb[0] : w_s;
   wire [3:0] pend = {modem_change_pend, line_error_pend, tx_empty_pend,
      rx_ready_pend};
   wire [3:0] act = en_sh & pend;
   wire [1:0] exp_id = act_q[2] ? 2'h3 : act_q[0] ? 2'h2 :
      act_q[1] ? 2'h1 : 2'h0;
   // shadow enable byte and last cycle's enabled sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'h0;
         w_held <= 1'h0;
         en_sh <= 4'h0;
         act_q <= 4'h0;
      end else begin
         aw_held <= (aw_held | aw_now) & ~wr_fire;
         w_held <= (w_held | w_now) & ~wr_fire;
         if (aw_now) aw_a <= s_axi_awaddr;
         if (w_now) w_d <= s_axi_wdata[7:0];
         if (w_now) w_s <= s_axi_wstrb[0];
         if (wr_fire && wr_s && wr_a == uieb_pkg::OFS_IRQ_EN) begin
            en_sh <= wr_d[3:0];
         end
         act_q <= act;
      end
   end
   chk_irq_raise: assert property (
      handshake_irq_gate && act != 4'h0 |=> port_irq) else $error("no irq");
   chk_irq_masked: assert property (
      act == 4'h0 |=> !port_irq) else $error("masked irq seen");
   chk_gate_off: assert property (
      !handshake_irq_gate |=> !port_irq) else $error("irq with gate low");
   chk_prio_code: assert property (
      !irq_none |-> irq_identity == exp_id) else $error("bad priority code");
   chk_none_flag: assert property (
      irq_none == (act_q == 4'h0)) else $error("bad none flag");
   chk_write_ans: assert property (
      wr_fire |=> s_axi_bvalid) else $error("write not answered");
   chk_read_ans: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no rvalid");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
   chk_tick_pulse: assert property (
      baud16_tick |=> !baud16_tick) else $error("tick too long");
endmodule : uieb_asserts
bind uieb_top uieb_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .line_error_pend, .rx_ready_pend, .tx_empty_pend, .modem_change_pend,
   .handshake_irq_gate, .port_irq, .irq_identity, .irq_none, .baud16_tick);

// File: uieb_top_tb.sv
// Purpose: register, interrupt and rate tests for uieb_top
// Assumes: 200 MHz aclk, bus driven by the xfer task
// Notes: tick counts allow a slack of two for divider phase
`timescale 1ns/1ps
module uieb_top_tb;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, port_irq, irq_none, baud16_tick, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, irq_identity, rs;
   logic line_error_pend = '0, rx_ready_pend = '0, tx_empty_pend = '0;
   logic modem_change_pend = '0, handshake_irq_gate = '0;
   int errors = 0, n_compared = 0, cyc = 0, n;
   logic [1:0] code [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   logic [3:0] pen [4] = '{4'hF, 4'hB, 4'hA, 4'h8};
   logic [7:0] cfg [6] = '{8'hC0, 8'hC0, 8'h00, 8'h01, 8'h02, 8'h00};
   logic [7:0] dv [6] = '{8'h01, 8'h03, 8'h01, 8'h01, 8'h01, 8'h02};
   int tk [6] = '{312, 104, 24, 192, 312, 12};
   always #2.5 aclk = ~aclk;
   uieb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_error_pend, .rx_ready_pend,
      .tx_empty_pend, .modem_change_pend, .handshake_irq_gate, .port_irq,
      .irq_identity, .irq_none, .baud16_tick, .irq);
   task automatic check(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic test_done;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // one bus transfer; holds each channel until its ready is sampled
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      logic pa, pw, pr, hit;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_awvalid <= 1'h1;
         s_axi_wdata <= d;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
      end
      hit = 1'h0;
      while (!hit) begin
         #1;
         pa = s_axi_awvalid & s_axi_awready;
         pw = s_axi_wvalid & s_axi_wready;
         pr = s_axi_arvalid & s_axi_arready;
         hit = w ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         rs = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (pa) s_axi_awvalid <= 1'h0;
         if (pw) s_axi_wvalid <= 1'h0;
         if (pr) s_axi_arvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
   endtask : xfer
   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      xfer(1'h0, a, '0);
      check(nm, q, e);
   endtask : rdc
   // drive the sources and gate, then wait for the registered outputs
   task automatic pend(input logic [3:0] p, input logic g);
      @(posedge aclk);
      {modem_change_pend, line_error_pend, tx_empty_pend, rx_ready_pend} <= p;
      handshake_irq_gate <= g;
      repeat (2) @(posedge aclk);
      #1;
   endtask : pend
   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      rdc("en reset", uieb_pkg::OFS_IRQ_EN, 32'h0);
      rdc("div lo reset", uieb_pkg::OFS_DIV_LO, 32'h1);
      xfer(1'h1, uieb_pkg::OFS_IRQ_EN, 32'hFFFFFFFF);
      rdc("en upper", uieb_pkg::OFS_IRQ_EN, 32'h0F);
      xfer(1'h1, uieb_pkg::OFS_SCRATCH, 32'hA5);
      rdc("scratch", uieb_pkg::OFS_SCRATCH, 32'hA5);
      rdc("div kept", uieb_pkg::OFS_DIV_LO, 32'h1);
      xfer(1'h1, uieb_pkg::OFS_DIV_LO, 32'h34);
      xfer(1'h1, uieb_pkg::OFS_DIV_HI, 32'h12);
      rdc("div lo", uieb_pkg::OFS_DIV_LO, 32'h34);
      rdc("div hi", uieb_pkg::OFS_DIV_HI, 32'h12);
      rdc("unmapped", 8'h40, 32'h0);
      check("rd resp", rs, uieb_pkg::RESP_SLVERR);
      xfer(1'h1, 8'h40, 32'h1);
      check("wr resp", rs, uieb_pkg::RESP_SLVERR);
      // each source alone: masked, enabled, then gated off
      for (int i = 0; i < 4; i++) begin
         xfer(1'h1, uieb_pkg::OFS_IRQ_EN, 32'h0);
         pend(4'h1 << i, 1'h1);
         check("masked", port_irq, 32'h0);
         check("none", irq_none, 32'h1);
         xfer(1'h1, uieb_pkg::OFS_IRQ_EN, 32'h1 << i);
         pend(4'h1 << i, 1'h1);
         check("enabled", port_irq, 32'h1);
         check("code", irq_identity, code[i]);
         rdc("ident", uieb_pkg::OFS_IDENT, {code[i], 1'h0});
         pend(4'h1 << i, 1'h0);
         check("gated", port_irq, 32'h0);
      end
      // all pending, enables pick which one wins
      for (int i = 0; i < 4; i++) begin
         xfer(1'h1, uieb_pkg::OFS_IRQ_EN, {28'h0, pen[i]});
         pend(4'hF, 1'h1);
         check("prio", irq_identity, 2'h3 - i);
      end
      // event interrupt: masked first, then unmasked
      for (int i = 0; i < 2; i++) begin
         xfer(1'h1, uieb_pkg::OFS_EVT_MASK, i);
         pend(4'h0, 1'h1);
         xfer(1'h0, uieb_pkg::OFS_EVT_STAT, '0);
         pend(4'hF, 1'h1);
         check("event irq", irq, i);
         xfer(1'h0, uieb_pkg::OFS_EVT_STAT, '0);
         check("stat bit", q[0], 32'h1);
         pend(4'hF, 1'h1);
         check("stat clear", irq, 32'h0);
      end
      // tick rate over 2600 cycles for each speed and pre-divider
      xfer(1'h1, uieb_pkg::OFS_DIV_HI, 32'h0);
      for (int i = 0; i < 6; i++) begin
         xfer(1'h1, uieb_pkg::OFS_CONFIG, {24'h0, cfg[i]});
         xfer(1'h1, uieb_pkg::OFS_DIV_LO, {24'h0, dv[i]});
         n = 0;
         repeat (2600) begin
            @(posedge aclk);
            #1;
            n += baud16_tick;
         end
         n = (n >= tk[i] - 2 && n <= tk[i] + 2);
         check("ticks", n, 32'h1);
         rdc("cfg back", uieb_pkg::OFS_CONFIG, {24'h0, cfg[i]});
         rdc("tick evt", uieb_pkg::OFS_EVT_STAT, 32'h2);
      end
      test_done();
   end
endmodule : uieb_top_tb
